// file: bench/occc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module occc_checker
  import occc_pkg::*;
#(
  parameter int CHANNELS = OCCC_CHANNELS
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [OCCC_ADDR_W-1:0] reg_addr,
  input wire logic [OCCC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [OCCC_DATA_W-1:0] reg_rdata,
  input wire logic [OCCC_DATA_W-1:0] timer_two_count,
  input wire logic [OCCC_DATA_W-1:0] timer_three_count,
  input wire logic cpu_idle,
  input wire logic [CHANNELS-1:0] compare_output_pin
);
  // channel 0 shadow; age keeps checks off until a mode change has settled
  logic [15:0] con_r;
  logic [15:0] cmp_r;
  logic [2:0] age_r;
  logic run;
  logic hit;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      con_r <= 16'h0000;
      cmp_r <= 16'h0000;
      age_r <= 3'h0;
    end
    else
    begin
      if (reg_write && reg_addr == 4'h1)
        cmp_r <= reg_wdata;
      if (reg_write && reg_addr == 4'h0)
        con_r <= reg_wdata;
      if (reg_write && reg_addr == 4'h0)
        age_r <= 3'h0;
      else if (age_r != 3'h7)
        age_r <= age_r + 3'h1;
    end
  assign run = age_r >= 3'h3 && !(con_r[13] && cpu_idle);
  assign hit = run && (con_r[3] ? timer_three_count : timer_two_count) == cmp_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_unimpl_zero: assert property (reg_read && (reg_addr == 4'h0 || reg_addr == 4'h4) |=>
    (reg_rdata & 16'hdfe0) == 16'h0000) else $error("unimplemented control bits not zero");
  a_fault_unused: assert property (reg_read && reg_addr == 4'h0 && age_r >= 3'h3 &&
    con_r[2:0] != 3'h7 |=> !reg_rdata[4]) else $error("fault status set outside fault mode");
  a_off_quiet: assert property (age_r >= 3'h3 && con_r[2:0] == 3'h0 |-> !compare_output_pin[0])
    else $error("pin active while disabled");
  a_match_high: assert property (hit && con_r[2:0] == 3'h1 |=> compare_output_pin[0])
    else $error("pin not high after match");
  a_match_low: assert property (hit && con_r[2:0] == 3'h2 |=> !compare_output_pin[0])
    else $error("pin not low after match");
  a_match_toggle: assert property (hit && con_r[2:0] == 3'h3 |=>
    compare_output_pin[0] != $past(compare_output_pin[0])) else $error("pin did not toggle");
  a_idle_hold: assert property (age_r >= 3'h3 && con_r[13] && cpu_idle && con_r[2:0] != 3'h0 &&
    con_r[2:1] != 2'h3 |=> $stable(compare_output_pin[0])) else $error("pin moved while idle stopped");
endmodule
`default_nettype wire

// file: bench/occc_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
// two free-running timers; period pulse in the cycle where a count is zero
module occc_timer_model #(
  parameter int P2 = 40,
  parameter int P3 = 64
)
(
  input wire logic clock,
  input wire logic rst_n,
  output logic [15:0] two_count,
  output logic two_period,
  output logic [15:0] three_count,
  output logic three_period
);
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      two_count <= 16'h0000;
      three_count <= 16'h0000;
    end
    else
    begin
      two_count <= (two_count == P2 - 1) ? 16'h0000 : two_count + 16'h0001;
      three_count <= (three_count == P3 - 1) ? 16'h0000 : three_count + 16'h0001;
    end
  assign two_period = two_count == 16'h0000;
  assign three_period = three_count == 16'h0000;
endmodule
`default_nettype wire

// file: bench/output_compare_channel_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module output_compare_channel_control_test;
  import occc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic cpu_idle = 1'b0;
  logic [1:0] fault_n = 2'h3;
  logic [15:0] reg_rdata;
  logic [15:0] t2_count;
  logic [15:0] t3_count;
  logic t2_period;
  logic t3_period;
  logic [1:0] pin;
  logic irq;
  logic [15:0] d;
  logic p;
  int fails = 0;
  int n_tests = 0;
  always #50 clock = ~clock;
  occc_top u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_two_count(t2_count),
    .timer_two_period(t2_period), .timer_three_count(t3_count), .timer_three_period(t3_period),
    .cpu_idle(cpu_idle), .pwm_fault_in_n(fault_n), .compare_output_pin(pin), .irq(irq));
  occc_timer_model u_tmr (.clock(clock), .rst_n(rst_n), .two_count(t2_count), .two_period(t2_period),
    .three_count(t3_count), .three_period(t3_period));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    chk("reg", e, d);
  endtask
  task automatic wait_pin(input int ch, input logic v, input int n);
    int i;
    @(negedge clock);
    for (i = 0; i < n && pin[ch] !== v; i++)
      @(negedge clock);
    chk("pin", {15'h0000, v}, {15'h0000, pin[ch]});
  endtask
  // counts cycles spent off the starting level over a span; zero means the pin held
  task automatic hold_pin(input int ch, input int n);
    int k;
    logic v;
    k = 0;
    @(negedge clock);
    v = pin[ch];
    repeat (n)
    begin
      @(negedge clock);
      k += (pin[ch] !== v);
    end
    chk("hold", 16'h0000, k[15:0]);
  endtask
  task automatic wrap_up;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rdc(4'h0, 16'h0000);
    rdc(4'h4, 16'h0000);
    rdc(4'h8, 16'h0000);
    rdc(4'h9, 16'h0000);
    wr(4'h0, 16'hffff);
    rdc(4'h0, 16'h200f);
    wr(4'h3, 16'h1234);
    rdc(4'h3, 16'h0000);
    // compare value beyond timer two's range: only timer three can match
    wr(4'h1, 16'h0032);
    wr(4'h0, 16'h0001);
    wait_pin(0, 1'b0, 4);
    hold_pin(0, 100);
    wr(4'h0, 16'h0009);
    wait_pin(0, 1'b1, 70);
    rdc(4'h8, 16'h0001);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(4'h9, 16'h0001);
    // irq takes the new mask one edge after the write lands
    repeat (2) @(negedge clock);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(4'h0, 16'h0000);
    wait_pin(0, 1'b0, 4);
    wr(4'h8, 16'h0001);
    hold_pin(0, 100);
    rdc(4'h8, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(4'h1, 16'h000a);
    wr(4'h2, 16'h001e);
    wr(4'h0, 16'h0002);
    wait_pin(0, 1'b1, 4);
    wait_pin(0, 1'b0, 50);
    wr(4'h0, 16'h0003);
    @(negedge clock);
    p = pin[0];
    wait_pin(0, ~p, 50);
    wait_pin(0, p, 50);
    wr(4'h0, 16'h2003);
    @(posedge clock);
    cpu_idle <= 1'b1;
    hold_pin(0, 100);
    @(posedge clock);
    cpu_idle <= 1'b0;
    @(negedge clock);
    p = pin[0];
    wait_pin(0, ~p, 50);
    wr(4'h0, 16'h0003);
    @(posedge clock);
    cpu_idle <= 1'b1;
    @(negedge clock);
    p = pin[0];
    wait_pin(0, ~p, 50);
    @(posedge clock);
    cpu_idle <= 1'b0;
    wr(4'h0, 16'h0004);
    wait_pin(0, 1'b0, 4);
    wait_pin(0, 1'b1, 50);
    wait_pin(0, 1'b0, 30);
    hold_pin(0, 100);
    wr(4'h0, 16'h0005);
    wait_pin(0, 1'b1, 50);
    wait_pin(0, 1'b0, 30);
    wait_pin(0, 1'b1, 50);
    // fault held active through both pwm modes: only mode 111 may react
    @(posedge clock);
    fault_n <= 2'h2;
    wr(4'h0, 16'h0006);
    wait_pin(0, 1'b0, 50);
    wait_pin(0, 1'b1, 50);
    rdc(4'h0, 16'h0006);
    wr(4'h0, 16'h0007);
    wait_pin(0, 1'b0, 6);
    hold_pin(0, 60);
    rdc(4'h0, 16'h0017);
    // compare events of modes 010 to 111 have set bit 0 again since it was cleared
    rdc(4'h8, 16'h0005);
    wr(4'h0, 16'h0007);
    rdc(4'h0, 16'h0017);
    @(posedge clock);
    fault_n <= 2'h3;
    repeat (60) @(negedge clock);
    rdc(4'h0, 16'h0007);
    wait_pin(0, 1'b1, 50);
    wr(4'h0, 16'h0000);
    wr(4'h5, 16'h0014);
    wr(4'h4, 16'h0001);
    wait_pin(1, 1'b1, 50);
    wrap_up();
  end
endmodule
bind occc_top occc_checker #(.CHANNELS(CHANNELS)) u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .timer_two_count(timer_two_count), .timer_three_count(timer_three_count), .cpu_idle(cpu_idle),
  .compare_output_pin(compare_output_pin));
`default_nettype wire

// file: include/occc_pkg.sv
package occc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and register map
  localparam int OCCC_DATA_W = 16;
  localparam int OCCC_ADDR_W = 4;
  localparam int OCCC_CHANNELS = 2;
  localparam int OCCC_CHAN_STRIDE = 4;

  localparam logic [1:0] OCCC_OFF_CON = 2'h0;
  localparam logic [1:0] OCCC_OFF_CMP = 2'h1;
  localparam logic [1:0] OCCC_OFF_SEC = 2'h2;
  localparam logic [3:0] OCCC_ADDR_STATUS = 4'h8;
  localparam logic [3:0] OCCC_ADDR_MASK = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int OCCC_BIT_IDLE = 13;
  localparam int OCCC_BIT_FAULT = 4;
  localparam int OCCC_BIT_TSEL = 3;
  localparam int OCCC_BIT_MODE = 0;
  localparam int OCCC_MODE_W = 3;

  localparam logic [15:0] OCCC_CON_RESET = 16'h0000;
  localparam logic [15:0] OCCC_VAL_RESET = 16'h0000;
  localparam logic [15:0] OCCC_CON_WMASK = 16'h200f;

  // status and mask layout: events in the low bits, faults above them
  localparam int OCCC_ST_EVENT = 0;
  localparam int OCCC_ST_FAULT = 2;
  localparam int OCCC_ST_W = 4;
  localparam logic [3:0] OCCC_ST_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    OCCC_MODE_OFF = 3'h0,
    OCCC_MODE_SET_HIGH = 3'h1,
    OCCC_MODE_SET_LOW = 3'h2,
    OCCC_MODE_TOGGLE = 3'h3,
    OCCC_MODE_SINGLE = 3'h4,
    OCCC_MODE_CONT = 3'h5,
    OCCC_MODE_PWM = 3'h6,
    OCCC_MODE_PWM_FAULT = 3'h7
  } occc_mode_type;

  typedef struct packed {
    logic idle_stop;
    logic timebase_select;
    occc_mode_type mode;
  } occc_ctrl_type;

  typedef struct packed {
    logic [15:0] count;
    logic period;
  } occc_timer_type;

endpackage

// file: rtl/occc_channel.sv
`timescale 1ns/1ps
`default_nettype none

module occc_channel
  import occc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire occc_ctrl_type ctrl,
  input wire logic [OCCC_DATA_W-1:0] cmp_value,
  input wire logic [OCCC_DATA_W-1:0] sec_value,
  input wire occc_timer_type timer_two,
  input wire occc_timer_type timer_three,
  input wire logic cpu_idle,
  input wire logic fault_active,
  output logic compare_output_pin,
  output logic compare_event,
  output logic pwm_fault_status
);

  typedef enum logic [1:0] {
    OCCC_PS_RISE,
    OCCC_PS_FALL,
    OCCC_PS_DONE
  } occc_pulse_type;

  occc_timer_type sel;
  logic run;
  logic match;
  logic sec_match;
  logic mode_new;
  occc_mode_type mode_prev_r;
  occc_pulse_type pulse_r;

  ////////////////////////////////////////////////////////////////////////////
  assign sel = ctrl.timebase_select ? timer_three : timer_two;
  assign run = !(ctrl.idle_stop && cpu_idle);
  assign match = run && (sel.count == cmp_value);
  assign sec_match = run && (sel.count == sec_value);
  assign mode_new = (ctrl.mode != mode_prev_r);
  assign compare_event = match && (ctrl.mode != OCCC_MODE_OFF) && !mode_new;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_prev_r <= OCCC_MODE_OFF;
    else
      mode_prev_r <= ctrl.mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse sequencer for the single and continuous pulse modes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pulse_r <= OCCC_PS_RISE;
    else if (mode_new)
      pulse_r <= OCCC_PS_RISE;
    else if (run)
    begin
      unique case (pulse_r)
        OCCC_PS_RISE:
          if (match)
            pulse_r <= OCCC_PS_FALL;
        OCCC_PS_FALL:
          if (sec_match)
            pulse_r <= (ctrl.mode == OCCC_MODE_CONT) ? OCCC_PS_RISE : OCCC_PS_DONE;
        OCCC_PS_DONE:
          pulse_r <= OCCC_PS_DONE;
        default:
          pulse_r <= OCCC_PS_RISE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pin; a mode change starts from the documented initial level, except toggle, which keeps the pin's current level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      compare_output_pin <= 1'b0;
    else if (mode_new)
    begin
      unique case (ctrl.mode)
        OCCC_MODE_SET_LOW: compare_output_pin <= 1'b1;
        OCCC_MODE_TOGGLE: compare_output_pin <= compare_output_pin;
        default: compare_output_pin <= 1'b0;
      endcase
    end
    else if (run)
    begin
      unique case (ctrl.mode)
        OCCC_MODE_OFF: compare_output_pin <= 1'b0;
        OCCC_MODE_SET_HIGH:
          if (match)
            compare_output_pin <= 1'b1;
        OCCC_MODE_SET_LOW:
          if (match)
            compare_output_pin <= 1'b0;
        OCCC_MODE_TOGGLE:
          if (match)
            compare_output_pin <= !compare_output_pin;
        OCCC_MODE_SINGLE, OCCC_MODE_CONT:
          if (pulse_r == OCCC_PS_RISE && match)
            compare_output_pin <= 1'b1;
          else if (pulse_r == OCCC_PS_FALL && sec_match)
            compare_output_pin <= 1'b0;
        OCCC_MODE_PWM, OCCC_MODE_PWM_FAULT:
          // in mode 111 a fault drives the pin low at once; period start wins over a duty match
          if (ctrl.mode == OCCC_MODE_PWM_FAULT && fault_active)
            compare_output_pin <= 1'b0;
          else if (sel.period)
            compare_output_pin <= (cmp_value != OCCC_VAL_RESET);
          else if (match)
            compare_output_pin <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault status: set by the pin, cleared by hardware at a clean period start
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pwm_fault_status <= 1'b0;
    else if (ctrl.mode != OCCC_MODE_PWM_FAULT)
      pwm_fault_status <= 1'b0;
    else if (fault_active)
      pwm_fault_status <= 1'b1;
    else if (run && sel.period)
      pwm_fault_status <= 1'b0;
  end

endmodule
`default_nettype wire

// file: rtl/occc_top.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module occc_top
  import occc_pkg::*;
#(
  parameter int CHANNELS = OCCC_CHANNELS
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [OCCC_ADDR_W-1:0] reg_addr,
  input wire logic [OCCC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [OCCC_DATA_W-1:0] reg_rdata,
  input wire logic [OCCC_DATA_W-1:0] timer_two_count,
  input wire logic timer_two_period,
  input wire logic [OCCC_DATA_W-1:0] timer_three_count,
  input wire logic timer_three_period,
  input wire logic cpu_idle,
  input wire logic [CHANNELS-1:0] pwm_fault_in_n,
  output logic [CHANNELS-1:0] compare_output_pin,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic chan_hit(
    input logic [OCCC_ADDR_W-1:0] addr,
    input int ch,
    input logic [1:0] off
  );
    logic [OCCC_ADDR_W-1:0] target;
    target = OCCC_ADDR_W'(ch * OCCC_CHAN_STRIDE) | OCCC_ADDR_W'(off);
    return addr == target;
  endfunction

  occc_timer_type timer_two;
  occc_timer_type timer_three;
  occc_ctrl_type ctrl_r [CHANNELS];
  logic [OCCC_DATA_W-1:0] cmp_r [CHANNELS];
  logic [OCCC_DATA_W-1:0] sec_r [CHANNELS];
  logic [CHANNELS-1:0] fault_meta_r;
  logic [CHANNELS-1:0] fault_sync_r;
  logic [CHANNELS-1:0] event_pulse;
  logic [CHANNELS-1:0] fault_status;
  logic [CHANNELS-1:0] fault_status_d_r;
  logic [OCCC_ST_W-1:0] status_r;
  logic [OCCC_ST_W-1:0] status_nxt;
  logic [OCCC_ST_W-1:0] mask_r;
  logic [OCCC_ST_W-1:0] status_set;
  logic [OCCC_DATA_W-1:0] rdata_nxt;

  assign timer_two = '{count: timer_two_count, period: timer_two_period};
  assign timer_three = '{count: timer_three_count, period: timer_three_period};

  ////////////////////////////////////////////////////////////////////////////
  // fault pins come from outside the clock domain: two flops before use

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_meta_r <= '0;
      fault_sync_r <= '0;
    end
    else
    begin
      fault_meta_r <= ~pwm_fault_in_n;
      fault_sync_r <= fault_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel registers and cores

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_ch
      // only bits 13, 3 and 2..0 are storage; the rest never reach a flop
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ctrl_r[g].idle_stop <= OCCC_CON_RESET[OCCC_BIT_IDLE];
          ctrl_r[g].timebase_select <= OCCC_CON_RESET[OCCC_BIT_TSEL];
          ctrl_r[g].mode <= occc_mode_type'(OCCC_CON_RESET[OCCC_BIT_MODE +: OCCC_MODE_W]);
        end
        else if (reg_write && chan_hit(reg_addr, g, OCCC_OFF_CON))
        begin
          ctrl_r[g].idle_stop <= reg_wdata[OCCC_BIT_IDLE];
          ctrl_r[g].timebase_select <= reg_wdata[OCCC_BIT_TSEL];
          ctrl_r[g].mode <= occc_mode_type'(reg_wdata[OCCC_BIT_MODE +: OCCC_MODE_W]);
        end
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          cmp_r[g] <= OCCC_VAL_RESET;
        else if (reg_write && chan_hit(reg_addr, g, OCCC_OFF_CMP))
          cmp_r[g] <= reg_wdata;
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          sec_r[g] <= OCCC_VAL_RESET;
        else if (reg_write && chan_hit(reg_addr, g, OCCC_OFF_SEC))
          sec_r[g] <= reg_wdata;
      end

      occc_channel u_channel (
        .clock(clock),
        .rst_n(rst_n),
        .ctrl(ctrl_r[g]),
        .cmp_value(cmp_r[g]),
        .sec_value(sec_r[g]),
        .timer_two(timer_two),
        .timer_three(timer_three),
        .cpu_idle(cpu_idle),
        .fault_active(fault_sync_r[g]),
        .compare_output_pin(compare_output_pin[g]),
        .compare_event(event_pulse[g]),
        .pwm_fault_status(fault_status[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: compare events and rising fault status are sticky

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fault_status_d_r <= '0;
    else
      fault_status_d_r <= fault_status;
  end

  always_comb
  begin
    status_set = '0;
    status_set[OCCC_ST_EVENT +: CHANNELS] = event_pulse;
    status_set[OCCC_ST_FAULT +: CHANNELS] = fault_status & ~fault_status_d_r;
  end

  // a set in the same cycle as a write-one-to-clear survives
  always_comb
  begin
    status_nxt = status_r;
    if (reg_write && reg_addr == OCCC_ADDR_STATUS)
      status_nxt = status_nxt & ~reg_wdata[OCCC_ST_W-1:0];
    status_nxt = status_nxt | status_set;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= OCCC_ST_RESET;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= OCCC_ST_RESET;
    else if (reg_write && reg_addr == OCCC_ADDR_MASK)
      mask_r <= reg_wdata[OCCC_ST_W-1:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      // status reaches irq at once; a mask write shows one cycle later
      irq <= |(status_nxt & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data appears the cycle after the strobe and only then

  always_comb
  begin
    rdata_nxt = '0;
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (chan_hit(reg_addr, c, OCCC_OFF_CON))
      begin
        // unimplemented bits stay zero
        rdata_nxt[OCCC_BIT_IDLE] = ctrl_r[c].idle_stop;
        rdata_nxt[OCCC_BIT_FAULT] = fault_status[c];
        rdata_nxt[OCCC_BIT_TSEL] = ctrl_r[c].timebase_select;
        rdata_nxt[OCCC_BIT_MODE +: OCCC_MODE_W] = ctrl_r[c].mode;
      end
      else if (chan_hit(reg_addr, c, OCCC_OFF_CMP))
        rdata_nxt = cmp_r[c];
      else if (chan_hit(reg_addr, c, OCCC_OFF_SEC))
        rdata_nxt = sec_r[c];
    end
    if (reg_addr == OCCC_ADDR_STATUS)
      rdata_nxt[OCCC_ST_W-1:0] = status_r;
    else if (reg_addr == OCCC_ADDR_MASK)
      rdata_nxt[OCCC_ST_W-1:0] = mask_r;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_read)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= '0;
  end

endmodule
`default_nettype wire
